// ==== hdl/fbs_pkg.sv ====
/*
  Constants, field layouts and carrier types for the burst read sequencer.
  Assumes a single 250 MHz clock domain shared with the host controller.
*/
`default_nettype none
package fbs_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RADDR_W = 4;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [RADDR_W-1:0] OFS_CFG = 4'h0;
  localparam logic [RADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [RADDR_W-1:0] OFS_CMD = 4'h8;
  localparam logic [RADDR_W-1:0] OFS_PTR = 4'hC;

  // ==========================================================
  // Configuration register fields
  localparam int unsigned CFG_WS_LSB = 0;
  localparam int unsigned CFG_WS_MSB = 3;
  localparam int unsigned CFG_MODE_LSB = 4;
  localparam int unsigned CFG_MODE_MSB = 5;
  localparam int unsigned CFG_RDYPOL_BIT = 6;
  localparam int unsigned CFG_ASYNC_BIT = 15;

  // Status register fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_STATE_MSB = 1;
  localparam int unsigned ST_ERR_BIT = 2;
  localparam int unsigned ST_BUSY_BIT = 3;

  // Command code that clears the error flag; arbitrary value
  localparam logic [7:0] CMD_SW_RESET = 8'hA5;

  // ==========================================================
  // Wait state figures in mclk cycles, wrap lengths in words
  localparam logic [3:0] WS_MIN = 4'h3;
  localparam logic [3:0] WS_MAX = 4'h9;
  localparam logic [3:0] WS_RESET = 4'h7;
  localparam logic [3:0] WS_GROUP = 4'h8;
  localparam logic [3:0] BOUNDARY_WS = 4'h1;
  localparam logic [4:0] WRAP8_LEN = 5'h08;
  localparam logic [4:0] WRAP16_LEN = 5'h10;

  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    MODE_CONT   = 2'h0,
    MODE_WRAP8  = 2'h1,
    MODE_WRAP16 = 2'h2
  } fbs_mode_t;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'h0,
    ST_LAT   = 2'h1,
    ST_RUN   = 2'h3,
    ST_STALL = 2'h2
  } fbs_state_t;

  typedef struct packed
  {
    logic       async_mode;
    logic       rdy_pol;
    logic [1:0] mode;
    logic [3:0] ws;
  } fbs_cfg_t;

  localparam fbs_cfg_t CFG_RESET = '{1'b1, 1'b1, 2'h0, WS_RESET};

  typedef struct packed
  {
    logic chip_select_n;
    logic output_enable_n;
    logic address_valid_n;
    logic hardware_reset_n;
  } fbs_ctl_t;

endpackage
`default_nettype wire

// ==== hdl/fbs_burst_seq.sv ====
/*
  Burst read sequencer of a multiplexed NOR flash: latency, wrap and
  continuous address sequencing, inserted waits and a small register port.
  Assumes host pins arrive already on mclk and the array answers mem_rdata
  combinationally for mem_addr.
  The controller drives its pins on mclk, so no synchronisers are used.
*/
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - With 7 waits, offsets above 1 add one wait each after group end.
// - With 6 waits, offsets above 2 add one wait each after group end.
// - With 5 waits, offsets above 3 add one wait each after group end.
// - With 4 waits, offsets above 4 add one wait each after group end.
// - With 3 waits, offsets 6 and 7 add one and two waits.
// - Continuous bursts roll the pointer over from top address to zero.
// - Continuous bursts end only on chip select high, hardware reset, new address.
// - The software reset command leaves a running burst untouched.
// - Wrap modes read a fixed 8 or 16 word aligned group.
// - Wrap bursts count up to group top, then resume at group base.
// - A 16 word wrap burst ends after all sixteen words.
// - Wrap bursts insert no waits beyond the initial latency.
// - Programmed wait count sets cycles from address valid to data.
// - After reset the wait count is seven.
// - Only wait counts three through nine are accepted.
// - Configuration holds waits, mode, ready polarity, sync flag.
// - Bursts start only while configuration bit 15 is clear.
// - wait_indicator marks initial latency and every inserted wait.
// - Crossing a 128 word boundary adds a wait in continuous mode.
// - After latency one word per cycle while output enable is low.
module fbs_burst_seq
  import fbs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire fbs_ctl_t          ctl,
  input  wire logic [ADDR_W-1:0] address_in,
  output logic      [DATA_W-1:0] adq_out,
  output logic                   adq_oe,
  output logic                   wait_indicator,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata
);

  // ==========================================================
  // Extra waits after the first group, from start offset and latency.
  // The threshold is the last offset whose group still runs unbroken:
  // a longer latency leaves the array less time to fetch the next row.
  function automatic logic [3:0] fbs_extra_ws
  (
    input logic [2:0] ofs,
    input logic [3:0] ws
  );
    logic [3:0] thr;
    thr = (ws >= WS_GROUP) ? 4'h0 : 4'(WS_GROUP - ws);
    return ({1'b0, ofs} > thr) ? 4'({1'b0, ofs} - thr) : 4'h0;
  endfunction

  function automatic logic [4:0] fbs_wrap_len
  (
    input logic [1:0] mode
  );
    return (mode == MODE_WRAP16) ? WRAP16_LEN : WRAP8_LEN;
  endfunction

  // ==========================================================
  // State
  fbs_state_t          state_r, state_nxt;
  fbs_cfg_t            cfg_r, cfg_nxt;
  logic [ADDR_W-1:0]   ptr_r, ptr_nxt;
  logic [1:0]          bmode_r, bmode_nxt;
  logic [3:0]          cnt_r, cnt_nxt;
  logic [3:0]          extra_r, extra_nxt;
  logic [4:0]          words_r, words_nxt;
  logic                first_done_r, first_done_nxt;
  logic                stalled_r, stalled_nxt;
  logic                valid_r, valid_nxt;
  logic                oe_r, oe_nxt;
  logic [DATA_W-1:0]   data_r, data_nxt;
  logic                err_r, err_nxt;
  logic [31:0]         rdata_r, rdata_nxt;

  logic                at_grp;
  logic                wrap;
  logic [3:0]          stall_cnt;
  logic [ADDR_W-1:0]   ptr_inc;
  logic                last_word;

  // ==========================================================
  // Burst sequencing
  // The capture edge loads ws-1, so the first word leaves its register
  // ws edges after the address; oe seen at one edge governs the next word.
  always_comb
  begin
    wrap = (bmode_r == MODE_WRAP8) || (bmode_r == MODE_WRAP16);
    // A group start reached by counting, never the start address itself
    at_grp = (ptr_r[2:0] == 3'h0) && (words_r != 5'h00);
    stall_cnt = (!first_done_r) ? extra_r : 4'h0;
    if (ptr_r[6:0] == 7'h00)
    begin
      stall_cnt = 4'(stall_cnt + BOUNDARY_WS);
    end
    if (wrap || !at_grp || stalled_r)
    begin
      stall_cnt = 4'h0;
    end
    // Only the low bits count in wrap modes, so the group base is kept
    // wrap inside the aligned group
    if (bmode_r == MODE_WRAP8)
    begin
      ptr_inc = {ptr_r[ADDR_W-1:3], 3'(ptr_r[2:0] + 3'h1)};
    end
    else if (bmode_r == MODE_WRAP16)
    begin
      ptr_inc = {ptr_r[ADDR_W-1:4], 4'(ptr_r[3:0] + 4'h1)};
    end
    else
    begin
      ptr_inc = ADDR_W'(ptr_r + 22'h000001);
    end
    // fixed length ends the wrap burst
    last_word = wrap && (words_r == 5'(fbs_wrap_len(bmode_r) - 5'h01));

    state_nxt = state_r;
    ptr_nxt = ptr_r;
    bmode_nxt = bmode_r;
    cnt_nxt = cnt_r;
    extra_nxt = extra_r;
    words_nxt = words_r;
    first_done_nxt = first_done_r;
    stalled_nxt = stalled_r;
    valid_nxt = 1'b0;
    data_nxt = data_r;

    if (!ctl.hardware_reset_n || ctl.chip_select_n)
    begin
      state_nxt = ST_IDLE;
    end
    // A new address restarts any burst, even one still in its latency
    // address accepted only in synchronous mode
    else if (!ctl.address_valid_n && !cfg_r.async_mode)
    begin
      state_nxt = ST_LAT;
      ptr_nxt = address_in;
      bmode_nxt = cfg_r.mode;
      // latency counter from the programmed count
      cnt_nxt = 4'(cfg_r.ws - 4'h1);
      extra_nxt = fbs_extra_ws(address_in[2:0], cfg_r.ws);
      words_nxt = 5'h00;
      first_done_nxt = 1'b0;
      stalled_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          state_nxt = ST_IDLE;
        end
        ST_LAT, ST_RUN, ST_STALL:
        begin
          if ((state_r == ST_LAT) && (cnt_r != 4'h0))
          begin
            cnt_nxt = 4'(cnt_r - 4'h1);
          end
          else if ((state_r == ST_STALL) && (cnt_r != 4'h0))
          begin
            cnt_nxt = 4'(cnt_r - 4'h1);
          end
          // advance only while output enable is low
          else if (!ctl.output_enable_n)
          begin
            // Stall cycles then count down whatever oe does, so a host
            // that pauses mid stall still sees the full insertion
            if ((state_r == ST_RUN) && (stall_cnt != 4'h0))
            begin
              // inserted waits show as not valid
              state_nxt = ST_STALL;
              cnt_nxt = 4'(stall_cnt - 4'h1);
              stalled_nxt = 1'b1;
              first_done_nxt = 1'b1;
            end
            else
            begin
              valid_nxt = 1'b1;
              data_nxt = mem_rdata;
              ptr_nxt = ptr_inc;
              stalled_nxt = 1'b0;
              if (at_grp)
              begin
                first_done_nxt = 1'b1;
              end
              // Saturate so a long continuous burst never looks fresh
              if (words_r != 5'h1F)
              begin
                words_nxt = 5'(words_r + 5'h01);
              end
              state_nxt = last_word ? ST_IDLE : ST_RUN;
            end
          end
          else if (state_r == ST_STALL)
          begin
            state_nxt = ST_RUN;
          end
        end
        default:
        begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    // Pins are driven through latency too, so the bus never floats mid burst
    oe_nxt = !ctl.output_enable_n && !ctl.chip_select_n &&
             (valid_nxt || (state_nxt != ST_IDLE));
  end

  // ==========================================================
  // Register port
  always_comb
  begin
    cfg_nxt = cfg_r;
    err_nxt = err_r;
    rdata_nxt = 32'h0000_0000;
    // One write per cycle, so setting and clearing err can never meet
    if (reg_wr && (reg_addr == OFS_CFG))
    begin
      // one register holds every burst setting
      cfg_nxt.async_mode = reg_wdata[CFG_ASYNC_BIT];
      cfg_nxt.rdy_pol = reg_wdata[CFG_RDYPOL_BIT];
      cfg_nxt.mode = reg_wdata[CFG_MODE_MSB:CFG_MODE_LSB];
      // out of range counts are refused and flagged
      if ((reg_wdata[CFG_WS_MSB:CFG_WS_LSB] >= WS_MIN) &&
          (reg_wdata[CFG_WS_MSB:CFG_WS_LSB] <= WS_MAX))
      begin
        cfg_nxt.ws = reg_wdata[CFG_WS_MSB:CFG_WS_LSB];
      end
      else
      begin
        err_nxt = 1'b1;
      end
    end
    // the reset command only clears the flag, never the burst
    else if (reg_wr && (reg_addr == OFS_CMD) &&
             (reg_wdata[7:0] == CMD_SW_RESET))
    begin
      err_nxt = 1'b0;
    end
    // Read data is registered, so it stands only in the cycle after reg_rd
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CFG:
        begin
          rdata_nxt[CFG_WS_MSB:CFG_WS_LSB] = cfg_r.ws;
          rdata_nxt[CFG_MODE_MSB:CFG_MODE_LSB] = cfg_r.mode;
          rdata_nxt[CFG_RDYPOL_BIT] = cfg_r.rdy_pol;
          rdata_nxt[CFG_ASYNC_BIT] = cfg_r.async_mode;
        end
        OFS_STATUS:
        begin
          rdata_nxt[ST_STATE_MSB:ST_STATE_LSB] = state_r;
          rdata_nxt[ST_ERR_BIT] = err_r;
          rdata_nxt[ST_BUSY_BIT] = (state_r != ST_IDLE);
        end
        OFS_PTR:
        begin
          rdata_nxt[ADDR_W-1:0] = ptr_r;
        end
        default:
        begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  // Synchronous reset keeps the pins quiet until the edge after release
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      cfg_r <= CFG_RESET;
      ptr_r <= '0;
      bmode_r <= MODE_CONT;
      cnt_r <= 4'h0;
      extra_r <= 4'h0;
      words_r <= 5'h00;
      first_done_r <= 1'b0;
      stalled_r <= 1'b0;
      valid_r <= 1'b0;
      oe_r <= 1'b0;
      data_r <= '0;
      err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      ptr_r <= ptr_nxt;
      bmode_r <= bmode_nxt;
      cnt_r <= cnt_nxt;
      extra_r <= extra_nxt;
      words_r <= words_nxt;
      first_done_r <= first_done_nxt;
      stalled_r <= stalled_nxt;
      valid_r <= valid_nxt;
      oe_r <= oe_nxt;
      data_r <= data_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign adq_out = data_r;
  assign adq_oe = oe_r;
  // Changing rdy_pol inside a burst flips the indicator at once;
  // hosts are expected to set it before the first address.
  // polarity chosen in configuration; wait when not valid
  assign wait_indicator = valid_r ~^ cfg_r.rdy_pol;
  assign mem_addr = ptr_r;
  assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// ==== test/fbs_array_model.sv ====
/*
  Flash array stand-in for the burst read sequencer.
  Assumes the sequencer reads it combinationally, one word per address.
*/
`timescale 1ns/10ps
`default_nettype none
module fbs_array_model
  import fbs_pkg::*;
(
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_rdata
);
  // ==========================================================
  // Data
  // Pattern differs from the address so stuck bits show
  assign mem_rdata = mem_addr[DATA_W-1:0] ^ 16'hA5C3;
endmodule
`default_nettype wire

// ==== test/fbs_burst_seq_chk.sv ====
/*
  Port checks for the burst read sequencer.
  Assumes ready polarity stays high, so high marks a valid word.
*/
`timescale 1ns/10ps
`default_nettype none
module fbs_burst_seq_chk
  import fbs_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire fbs_ctl_t          ctl,
  input wire logic              adq_oe,
  input wire logic              wait_indicator,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_take;
    !ctl.address_valid_n && !ctl.chip_select_n && ctl.hardware_reset_n;
  endsequence
  // Shortest legal latency is three cycles
  sequence s_lat;
    !wait_indicator [*3];
  endsequence
  property p_lat;
    s_take |=> s_lat;
  endproperty
  property p_oe_out;
    ctl.output_enable_n || ctl.chip_select_n |=> !adq_oe;
  endproperty
  property p_oe_gate;
    $past(ctl.output_enable_n) |-> !wait_indicator;
  endproperty
  property p_step;
    wait_indicator && $past(wait_indicator) |->
      mem_addr[2:0] == $past(mem_addr[2:0]) + 3'h1;
  endproperty
  property p_cs_end;
    ctl.chip_select_n |=> !wait_indicator;
  endproperty
  property p_cs_hold;
    ctl.chip_select_n [*2] |=> $stable(mem_addr);
  endproperty
  property p_hw_end;
    !ctl.hardware_reset_n |=> !wait_indicator [*2];
  endproperty
  property p_rd_zero;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  // ==========================================================
  // Assertions
  a_lat: assert property (p_lat)
    else $error("data inside initial latency");
  a_oe_out: assert property (p_oe_out)
    else $error("pins driven without enables");
  a_oe_gate: assert property (p_oe_gate)
    else $error("word given without output enable");
  a_step: assert property (p_step)
    else $error("pointer did not step by one");
  a_cs_end: assert property (p_cs_end)
    else $error("word after deselect");
  a_cs_hold: assert property (p_cs_hold)
    else $error("pointer moved while deselected");
  a_hw_end: assert property (p_hw_end)
    else $error("word after hardware reset");
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside read slot");
endmodule
bind fbs_burst_seq fbs_burst_seq_chk chk_u (.mclk(mclk), .reset_n(reset_n),
  .ctl(ctl), .adq_oe(adq_oe), .wait_indicator(wait_indicator),
  .mem_addr(mem_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the burst read sequencer.
  Assumes the array stand-in and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import fbs_pkg::*;
  ;
  logic               mclk;
  logic               reset_n;
  fbs_ctl_t           ctl;
  logic [ADDR_W-1:0]  address_in;
  logic [ADDR_W-1:0]  mem_addr;
  logic [DATA_W-1:0]  mem_rdata;
  logic [DATA_W-1:0]  adq_out;
  logic               adq_oe;
  logic               wait_indicator;
  logic [RADDR_W-1:0] reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  int                 failures = 0;
  int                 n_checks = 0;
  int                 cyc = 0;

  fbs_burst_seq dut_u (.mclk(mclk), .reset_n(reset_n), .ctl(ctl),
    .address_in(address_in), .adq_out(adq_out), .adq_oe(adq_oe),
    .wait_indicator(wait_indicator), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fbs_array_model mem_u (.mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // ==========================================================
  // Clock and guard
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      stop_test();
    end
  end

  // ==========================================================
  // Tasks
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: %h %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task quiet(input int c);
    repeat (c)
    begin
      @(posedge mclk);
      #1;
      chk({31'h0, wait_indicator}, 32'h0);
    end
  endtask
  task run(input logic [3:0] ws, input logic [1:0] md,
           input logic [21:0] st, input int n);
    logic [21:0] a;
    int k;
    int due;
    int off;
    wr(OFS_CFG, {16'h0, 9'h0, 1'b1, md, ws});
    @(posedge mclk);
    ctl.address_valid_n <= 1'b0;
    ctl.output_enable_n <= 1'b1;
    address_in <= st;
    @(posedge mclk);
    ctl.address_valid_n <= 1'b1;
    ctl.output_enable_n <= 1'b0;
    a = st;
    k = 0;
    off = st[2:0];
    // first word ws edges after capture
    due = ws;
    for (int t = 1; t < 80 && k < n; t++)
    begin
      @(posedge mclk);
      reg_addr <= OFS_CMD;
      reg_wdata <= {24'h0, CMD_SW_RESET};
      reg_wr <= (t == 3);
      #1;
      if (wait_indicator === 1'b1)
      begin
        chk(adq_out, a[15:0] ^ 16'hA5C3);
        chk(t, due);
        chk({31'h0, adq_oe}, 32'h1);
        k++;
        due++;
        if (md == 2'h1)
          a[2:0] = a[2:0] + 3'h1;
        else if (md == 2'h2)
          a[3:0] = a[3:0] + 4'h1;
        else
        begin
          a = a + 22'h1;
          if (k == 8 - off && off + ws > 8)
            due = due + off + ws - 8;
          if (a[6:0] == 7'h0)
            due++;
        end
      end
    end
    chk(k, n);
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    reset_n = 1'b0;
    ctl = '1;
    address_in = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFS_CFG, 32'h8047);
    @(posedge mclk);
    ctl.chip_select_n <= 1'b0;
    ctl.address_valid_n <= 1'b0;
    @(posedge mclk);
    ctl.address_valid_n <= 1'b1;
    ctl.output_enable_n <= 1'b0;
    quiet(12);
    for (int b = 2; b <= 10; b += 8)
    begin
      wr(OFS_CFG, 32'h40 + b);
      rd(OFS_CFG, 32'h47);
      rd(OFS_STATUS, 32'h4);
      wr(OFS_CMD, {24'h0, CMD_SW_RESET});
    end
    rd(OFS_STATUS, 32'h0);
    rd(4'h2, 32'h0);
    wr(OFS_CFG, 32'h49);
    rd(OFS_CFG, 32'h49);
    // Each run after the first restarts the previous burst with a new address
    for (int w = 3; w <= 7; w++)
    begin
      run(4'(w), 2'h0, 22'(32'h1008 - w), 10);
      run(4'(w), 2'h0, 22'(32'h100A - w), 10);
    end
    run(4'h3, 2'h0, 22'h3FFFFE, 6);
    run(4'h4, 2'h3, 22'h000100, 4);
    run(4'h5, 2'h1, 22'h00003A, 8);
    quiet(4);
    run(4'h4, 2'h2, 22'h000035, 16);
    quiet(4);
    run(4'h3, 2'h0, 22'h000020, 3);
    @(posedge mclk);
    ctl.chip_select_n <= 1'b1;
    quiet(6);
    @(posedge mclk);
    ctl.chip_select_n <= 1'b0;
    run(4'h3, 2'h0, 22'h000040, 3);
    @(posedge mclk);
    ctl.hardware_reset_n <= 1'b0;
    @(posedge mclk);
    ctl.hardware_reset_n <= 1'b1;
    quiet(6);
    stop_test();
  end
endmodule
`default_nettype wire
